// >>> rtl/ulef_map.svh
// register offsets, field positions, reset values and sizes of the
// receive line-error block; included by the design and the bench
`ifndef ULEF_MAP_SVH
`define ULEF_MAP_SVH

// byte offsets on the register bus
`define ULEF_RXDATA_OFF   6'h00
`define ULEF_IER_OFF      6'h04
`define ULEF_FIFOCTL_OFF  6'h08
`define ULEF_LCR_OFF      6'h0C
`define ULEF_LSR_OFF      6'h14
`define ULEF_DIV_OFF      6'h18
`define ULEF_STS_OFF      6'h1C
`define ULEF_MSK_OFF      6'h20

// line status bits
`define ULEF_LSR_DR       0
`define ULEF_LSR_PE       2
`define ULEF_LSR_FE       3
`define ULEF_LSR_BI       4

// interrupt enable, fifo control and line control fields
`define ULEF_IER_LINE_STATUS_IRQ_ENABLE     2
`define ULEF_FIFOCTL_EN   0
`define ULEF_LCR_STB      2
`define ULEF_LCR_PEN      3
`define ULEF_LCR_EPS      4

// stored entry: error bits above the data byte
`define ULEF_ENT_PE       8
`define ULEF_ENT_FE       9
`define ULEF_ENT_BI       10

// reset values
`define ULEF_LCR_RST      8'h03
`define ULEF_DIV_RST      16'h0010

// receive fifo depth
`define ULEF_FIFO_DEPTH   16

`endif

// >>> rtl/ulef_pkg.sv
// types of the receive line-error block
// assumes nothing of its surroundings
package ulef_pkg;

    // receiver states, one-hot
    typedef enum logic [5:0] {
        RX_IDLE   = 6'h01,
        RX_START  = 6'h02,
        RX_DATA   = 6'h04,
        RX_PARITY = 6'h08,
        RX_STOP   = 6'h10,
        RX_WAITHI = 6'h20
    } ulef_rx_state_t;

    typedef logic [10:0] ulef_entry_t;

endpackage : ulef_pkg

// >>> rtl/ulef_rx.sv
// serial receiver with break, framing and parity flags, receive fifo,
// line status and interrupt logic behind an avalon-mm slave
// assumes one 100 MHz clock and a receive line synchronous to it
//
// Summary of operation
// - a line held low longer than one full-word time sets the break flag, bit 4.
// - the full-word time is start, data, parity and stop bits together.
// - a set break flag with the line-status interrupt enable at 1 raises the interrupt.
// - without fifo the break flag belongs to the held character and clears when it is read.
// - with fifo the break flag shows the top character and clears on read unless the next has one.
// - a character without a valid stop bit sets the framing flag, bit 3.
// - after a framing error the receiver waits for the line to go high before a new start.
// - a set framing flag with the line-status interrupt enable at 1 raises the interrupt.
// - without fifo the framing flag belongs to the held character and clears when it is read.
// - with fifo the framing flag shows the top character and clears on read unless the next has one.
// - a parity differing from the even-parity-select choice sets the parity flag, bit 2.
// - a set parity flag with the line-status interrupt enable at 1 raises the interrupt.
// - the parity flag follows the held or top character and clears on its read.
`timescale 1ns/1ns
`include "ulef_map.svh"

module ulef_rx (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic [5:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        serial_receive_input,
    output logic             irq
);

    // ****************************************************************
    // functions
    // ****************************************************************

    // bits in one word: start, data, parity, stop
    function automatic logic [3:0] ulef_frame_bits(input logic [7:0] line_control_reg);
        logic [3:0] n;
        n = 4'h6 + {2'h0, line_control_reg[1:0]} + {3'h0, line_control_reg[`ULEF_LCR_PEN]}
            + {3'h0, line_control_reg[`ULEF_LCR_STB]} + 4'h1;
        return n;
    endfunction : ulef_frame_bits

    // data bits in one word
    function automatic logic [3:0] ulef_data_bits(input logic [7:0] line_control_reg);
        return 4'h5 + {2'h0, line_control_reg[1:0]};
    endfunction : ulef_data_bits

    // parity mismatch against the selected sense
    function automatic logic ulef_par_err(input logic [7:0] d,
                                          input logic       p,
                                          input logic [7:0] line_control_reg);
        return line_control_reg[`ULEF_LCR_PEN] & ((^d ^ p) == line_control_reg[`ULEF_LCR_EPS]);
    endfunction : ulef_par_err

    // ****************************************************************
    // registers and state
    // ****************************************************************

    ulef_pkg::ulef_rx_state_t st_q, st_d;
    logic [15:0] cnt_q, cnt_d;
    logic [3:0]  bit_q, bit_d;
    logic [7:0]  shift_q, shift_d;
    logic        par_q, par_d;
    logic        pend_q, pend_d;
    logic [20:0] low_q, low_d;
    logic [7:0]  lcr_q;
    logic [15:0] div_q;
    logic        line_status_irq_enable_q;
    logic        fifo_en_q;
    logic [2:0]  msk_q;
    logic [2:0]  sts_q, sts_d;
    logic [4:0]  wptr_q, wptr_d;
    logic [4:0]  rptr_q, rptr_d;
    logic [31:0] readdata_q;
    logic        waitrequest_q;
    logic        irq_q, irq_d;
    ulef_pkg::ulef_entry_t mem [0:`ULEF_FIFO_DEPTH-1];

    // ****************************************************************
    // bus decode
    // ****************************************************************

    // a request completes at the edge where waitrequest is seen low
    wire         req      = read | write;
    wire         acc      = clk_en & req & ~waitrequest_q;
    wire         a_rx     = address == `ULEF_RXDATA_OFF;
    wire         a_ier    = address == `ULEF_IER_OFF;
    wire         a_fifo   = address == `ULEF_FIFOCTL_OFF;
    wire         a_lcr    = address == `ULEF_LCR_OFF;
    wire         a_lsr    = address == `ULEF_LSR_OFF;
    wire         a_div    = address == `ULEF_DIV_OFF;
    wire         a_sts    = address == `ULEF_STS_OFF;
    wire         a_msk    = address == `ULEF_MSK_OFF;
    wire         wr_ier   = acc & write & a_ier;
    wire         wr_fifo  = acc & write & a_fifo;
    wire         wr_lcr   = acc & write & a_lcr;
    wire         wr_div   = acc & write & a_div;
    wire         wr_msk   = acc & write & a_msk;
    wire         pop      = acc & read & a_rx;
    wire         sts_clr  = acc & read & a_sts;
    wire         flush    = wr_fifo &
                            (writedata[`ULEF_FIFOCTL_EN] != fifo_en_q);

    // ****************************************************************
    // receive fifo view
    // ****************************************************************

    // flags always show the oldest unread character
    wire [4:0]   count    = wptr_q - rptr_q;
    wire         valid    = count != 5'h00;
    wire         full     = count == 5'(`ULEF_FIFO_DEPTH);
    wire [10:0]  top      = mem[rptr_q[3:0]];
    wire         lsr_bi   = valid & top[`ULEF_ENT_BI];
    wire         lsr_fe   = valid & top[`ULEF_ENT_FE];
    wire         lsr_pe   = valid & top[`ULEF_ENT_PE];
    wire [2:0]   lsr_err  = {lsr_bi, lsr_fe, lsr_pe};

    // line status and read mux
    wire [31:0]  lsr_w    = {27'h000_0000, lsr_bi, lsr_fe, lsr_pe,
                             1'b0, valid};
    wire [31:0]  rd_mux   = a_rx   ? {21'h00_0000, 3'h0, top[7:0]} :
                            a_ier  ? {29'h0000_0000, line_status_irq_enable_q, 2'h0} :
                            a_fifo ? {31'h0000_0000, fifo_en_q} :
                            a_lcr  ? {24'h00_0000, lcr_q} :
                            a_lsr  ? lsr_w :
                            a_div  ? {16'h0000, div_q} :
                            a_sts  ? {27'h000_0000, sts_q, 2'h0} :
                            a_msk  ? {27'h000_0000, msk_q, 2'h0} :
                            32'h0000_0000;

    // ****************************************************************
    // receiver timing
    // ****************************************************************

    // full-word time in clock cycles for the present setting
    wire [19:0]  frame_cyc = {16'h0000, ulef_frame_bits(lcr_q)} *
                             {4'h0, div_q};
    wire         brk_hit  = low_q > {1'b0, frame_cyc};
    wire         rxd      = serial_receive_input;
    wire         tick     = cnt_q == 16'h0000;
    wire [15:0]  div_m1   = div_q - 16'h0001;
    wire [3:0]   nbits    = ulef_data_bits(lcr_q);
    wire [7:0]   data_al  = shift_q >> (4'h8 - nbits);

    // character completion and its flags
    wire         st_stop  = st_q == ulef_pkg::RX_STOP;
    wire         st_wait  = st_q == ulef_pkg::RX_WAITHI;
    wire         push_ok  = st_stop & tick & rxd;
    wire         push_brk = st_wait & pend_q & brk_hit;
    wire         push_fe  = st_wait & pend_q & rxd & ~brk_hit;
    wire         push     = clk_en & (push_ok | push_brk | push_fe);
    wire         e_pe     = ulef_par_err(data_al, par_q, lcr_q);
    wire [10:0]  entry    = {push_brk, push_brk | push_fe, e_pe,
                             data_al};

    // without fifo a new character replaces the held one
    wire         mem_we   = push & ~flush & (fifo_en_q ? ~full : 1'b1);
    wire         replace  = ~fifo_en_q & valid;
    wire [3:0]   wr_idx   = replace ? rptr_q[3:0] : wptr_q[3:0];

    // ****************************************************************
    // receiver state machine
    // ****************************************************************

    // next state of the serial receiver
    always_comb begin
        st_d    = st_q;
        cnt_d   = tick ? cnt_q : cnt_q - 16'h0001;
        bit_d   = bit_q;
        shift_d = shift_q;
        par_d   = par_q;
        pend_d  = pend_q;
        case (st_q)
            ulef_pkg::RX_IDLE: begin
                if (!rxd) begin
                    cnt_d = {1'b0, div_q[15:1]};
                    st_d  = ulef_pkg::RX_START;
                end
            end
            ulef_pkg::RX_START: begin
                if (tick) begin
                    cnt_d = div_m1;
                    bit_d = 4'h0;
                    st_d  = rxd ? ulef_pkg::RX_IDLE : ulef_pkg::RX_DATA;
                end
            end
            ulef_pkg::RX_DATA: begin
                if (tick) begin
                    cnt_d   = div_m1;
                    shift_d = {rxd, shift_q[7:1]};
                    bit_d   = bit_q + 4'h1;
                    if (bit_q == nbits - 4'h1) begin
                        st_d = lcr_q[`ULEF_LCR_PEN] ? ulef_pkg::RX_PARITY
                                                    : ulef_pkg::RX_STOP;
                    end
                end
            end
            ulef_pkg::RX_PARITY: begin
                if (tick) begin
                    cnt_d = div_m1;
                    par_d = rxd;
                    st_d  = ulef_pkg::RX_STOP;
                end
            end
            ulef_pkg::RX_STOP: begin
                if (tick) begin
                    // bad stop bit: hold the character until line high or the low time passes a full word
                    st_d   = rxd ? ulef_pkg::RX_IDLE
                                 : ulef_pkg::RX_WAITHI;
                    pend_d = ~rxd;
                end
            end
            ulef_pkg::RX_WAITHI: begin
                if (push_brk) begin
                    pend_d = 1'b0;
                end
                if (rxd) begin
                    pend_d = 1'b0;
                    st_d   = ulef_pkg::RX_IDLE;
                end
            end
            default: begin
                st_d = ulef_pkg::RX_IDLE;
            end
        endcase
    end

    // low-time counter, saturating
    assign low_d = rxd ? 21'h00_0000
                 : (low_q == 21'h1F_FFFF ? low_q : low_q + 21'h00_0001);

    // ****************************************************************
    // fifo pointers, status and interrupt
    // ****************************************************************

    // pointer moves; a mode change empties the fifo
    assign wptr_d = flush ? 5'h00
                  : (mem_we & ~replace ? wptr_q + 5'h01 : wptr_q);
    assign rptr_d = flush ? 5'h00
                  : (pop & valid ? rptr_q + 5'h01 : rptr_q);

    // sticky events; a set in the clearing cycle wins
    assign sts_d = (sts_q & ~(sts_clr ? readdata_q[4:2] : 3'h0))
                 | (push ? entry[10:8] : 3'h0);

    // error flags with enable, or unmasked sticky events
    assign irq_d = (line_status_irq_enable_q & (|lsr_err))
                 | (|(sts_q & msk_q));

    // ****************************************************************
    // flip-flops
    // ****************************************************************

    // receiver state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q    <= ulef_pkg::RX_IDLE;
            cnt_q   <= 16'h0000;
            bit_q   <= 4'h0;
            shift_q <= 8'h00;
            par_q   <= 1'b0;
            pend_q  <= 1'b0;
            low_q   <= 21'h00_0000;
        end else if (clk_en) begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            bit_q   <= bit_d;
            shift_q <= shift_d;
            par_q   <= par_d;
            pend_q  <= pend_d;
            low_q   <= low_d;
        end
    end

    // software registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lcr_q     <= `ULEF_LCR_RST;
            div_q     <= `ULEF_DIV_RST;
            line_status_irq_enable_q    <= 1'b0;
            fifo_en_q <= 1'b0;
            msk_q     <= 3'h0;
        end else begin
            if (wr_lcr) lcr_q <= writedata[7:0];
            if (wr_div) div_q <= writedata[15:0];
            if (wr_ier) line_status_irq_enable_q <= writedata[`ULEF_IER_LINE_STATUS_IRQ_ENABLE];
            if (wr_fifo) fifo_en_q <= writedata[`ULEF_FIFOCTL_EN];
            if (wr_msk) msk_q <= writedata[4:2];
        end
    end

    // fifo pointers, status, interrupt and bus answer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wptr_q        <= 5'h00;
            rptr_q        <= 5'h00;
            sts_q         <= 3'h0;
            irq_q         <= 1'b0;
            readdata_q    <= 32'h0000_0000;
            waitrequest_q <= 1'b1;
        end else if (clk_en) begin
            wptr_q        <= wptr_d;
            rptr_q        <= rptr_d;
            sts_q         <= sts_d;
            irq_q         <= irq_d;
            if (req & waitrequest_q) readdata_q <= rd_mux;
            waitrequest_q <= ~(req & waitrequest_q);
        end
    end

    // entry storage, flags kept with each character
    always_ff @(posedge clock) begin
        if (mem_we) mem[wr_idx] <= entry;
    end

    assign readdata    = readdata_q;
    assign waitrequest = waitrequest_q;
    assign irq         = irq_q;

    // ****************************************************************
    // checks
    // ****************************************************************

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    brk_thresh_a:
    assert property (push && entry[`ULEF_ENT_BI] |-> low_q > {1'b0, frame_cyc})
        else $error("break flagged before full-word time");

    frame_len_a:
    assert property (frame_cyc == ulef_frame_bits(lcr_q) * div_q)
        else $error("full-word time miscounted");

    brk_irq_a:
    assert property (clk_en && line_status_irq_enable_q && lsr_bi |=> irq_q)
        else $error("break flag without interrupt");

    nofifo_one_a:
    assert property (!fifo_en_q |-> count <= 5'h01)
        else $error("more than one held character");

    fifo_next_a:
    assert property (clk_en && fifo_en_q && pop && !push && count == 5'h02
                     && !mem[rptr_q[3:0] + 4'h1][`ULEF_ENT_BI]
                     |=> !lsr_bi)
        else $error("break flag kept after clean character");

    fe_stop_a:
    assert property (clk_en && st_stop && tick && !rxd
                     |=> st_q == ulef_pkg::RX_WAITHI && pend_q)
        else $error("bad stop bit not caught");

    fe_wait_a:
    assert property (st_wait && !rxd |=> st_q == ulef_pkg::RX_WAITHI)
        else $error("receiver left wait with line low");

    fe_irq_a:
    assert property (clk_en && line_status_irq_enable_q && lsr_fe |=> irq_q)
        else $error("framing flag without interrupt");

    rd_clear_a:
    assert property (clk_en && !fifo_en_q && pop && !push && !flush
                     |=> !lsr_fe && !lsr_bi && !lsr_pe)
        else $error("flags kept after held character read");

    pe_calc_a:
    assert property (push && lcr_q[`ULEF_LCR_PEN]
                     |-> entry[`ULEF_ENT_PE]
                         == ((^data_al ^ par_q) == lcr_q[`ULEF_LCR_EPS]))
        else $error("parity flag wrong");

    pe_irq_a:
    assert property (clk_en && line_status_irq_enable_q && lsr_pe |=> irq_q)
        else $error("parity flag without interrupt");

    bus_done_a:
    assert property (clk_en && req && waitrequest |=> !waitrequest)
        else $error("bus answer late");

    brk_seen_c: cover property (push && entry[`ULEF_ENT_BI]);
    fe_only_c:  cover property (push && entry[`ULEF_ENT_FE]
                                && !entry[`ULEF_ENT_BI]);
    fifo_pe_c:  cover property (fifo_en_q && push && entry[`ULEF_ENT_PE]);
    irq_rise_c: cover property (!irq_q ##1 irq_q);

endmodule : ulef_rx

// >>> test/uart_rx_line_error_flags_bench.sv
// self-checking bench of the receive line-error block
// assumes the design and the serial line model are compiled first
`timescale 1ns/1ns
`include "ulef_map.svh"

module uart_rx_line_error_flags_bench;
    logic        clock;
    logic        rst_n;
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        serial_receive_input;
    logic        irq;
    logic        go;
    logic [11:0] frame;
    logic [8:0]  len;
    logic        busy;
    logic [31:0] exp_q[$];
    logic [7:0]  d[4];
    logic [31:0] lsr_tab[4];
    logic [11:0] fr_tab[4];
    logic [8:0]  len_tab[4];
    integer      seed;
    int          miscompares;
    int          comparisons;
    int          cycles;

    ulef_rx dut (.clock(clock), .rst_n(rst_n), .clk_en(1'b1),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest),
        .serial_receive_input(serial_receive_input), .irq(irq));

    ulef_line_model line (.clock(clock), .rst_n(rst_n), .go(go),
        .frame(frame), .len(len), .div(8'h10), .busy(busy),
        .serial_receive_input(serial_receive_input));

    // ****************************************
    // tasks
    // ****************************************
    task automatic check_word(input string n, input logic [31:0] e,
                              input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : check_word

    task automatic check_irq(input logic e);
        comparisons++;
        if (irq !== e) begin
            miscompares++;
            $display("[ERR] irq expected %b seen %b", e, irq);
        end
    endtask : check_irq

    // one avalon access; a read notes its expected data first
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] v);
        @(posedge clock);
        if (!wr) exp_q.push_back(v);
        address   <= a;
        writedata <= wr ? v : 32'h0000_0000;
        write     <= wr;
        read      <= !wr;
        do @(posedge clock); while (waitrequest !== 1'b0);
        write <= 1'b0;
        read  <= 1'b0;
    endtask : bus

    // hand one frame to the line model and let the receiver settle
    task automatic send(input logic [11:0] f, input logic [8:0] l);
        @(posedge clock);
        frame <= f;
        len   <= l;
        go    <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        repeat (int'(l) + 20) @(posedge clock);
    endtask : send

    // frame: start, data lsb first, even parity, stop, idle
    function automatic logic [11:0] fr(input logic [7:0] v,
                                       input logic ok, input logic st);
        return {1'b1, st, (^v) ^ !ok, v, 1'b0};
    endfunction : fr

    task automatic print_verdict();
        $display("comparisons %0d miscompares %0d", comparisons,
                 miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    // ****************************************
    // processes
    // ****************************************
    // clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // read data taken at the completing edge against the oldest note
    always @(posedge clock) begin
        if (read === 1'b1 && waitrequest === 1'b0)
            check_word("readdata", exp_q.pop_front(), readdata);
    end

    // hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end

    // main sequence
    initial begin
        rst_n = 1'b0;
        address = 6'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        go = 1'b0;
        frame = 12'hfff;
        len = 9'h000;
        seed = 32'hb1f6;
        miscompares = 0;
        comparisons = 0;
        cycles = 0;
        lsr_tab = '{32'h0000_0001, 32'h0000_0005, 32'h0000_0009,
                    32'h0000_0019};
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        // reset values, read-only status, unmapped place
        bus(1'b0, `ULEF_LSR_OFF, 32'h0000_0000);
        bus(1'b1, `ULEF_LSR_OFF, 32'hffff_ffff);
        bus(1'b0, `ULEF_LSR_OFF, 32'h0000_0000);
        bus(1'b0, `ULEF_LCR_OFF, 32'h0000_0003);
        bus(1'b0, `ULEF_DIV_OFF, 32'h0000_0010);
        bus(1'b1, 6'h3C, 32'hffff_ffff);
        bus(1'b0, 6'h3C, 32'h0000_0000);
        check_irq(1'b0);
        bus(1'b1, `ULEF_LCR_OFF, 32'h0000_001B);
        bus(1'b1, `ULEF_IER_OFF, 32'h0000_0004);
        bus(1'b1, `ULEF_DIV_OFF, 32'h0000_0010);
        $display("test reset done");
        // good, parity, framing and break characters, one at a time
        for (int k = 0; k < 4; k++) begin
            d[k] = (k == 3) ? 8'h00 : 8'($random(seed));
            // break: line held low through every bit, longer than a word
            fr_tab[k] = (k == 3) ? 12'h000 : fr(d[k], k != 1, k != 2);
            len_tab[k] = (k == 3) ? 9'd236 : (k == 2) ? 9'd172 : 9'd176;
            send(fr_tab[k], len_tab[k]);
            bus(1'b0, `ULEF_LSR_OFF, lsr_tab[k]);
            check_irq(k != 0);
            bus(1'b0, `ULEF_RXDATA_OFF, {24'h0, d[k]});
            bus(1'b0, `ULEF_LSR_OFF, 32'h0000_0000);
            repeat (3) @(posedge clock);
            check_irq(1'b0);
        end
        $display("test single done");
        // same four queued in the fifo, flags follow each entry
        bus(1'b1, `ULEF_FIFOCTL_OFF, 32'h0000_0001);
        for (int k = 0; k < 4; k++)
            send(fr_tab[k], len_tab[k]);
        for (int k = 0; k < 4; k++) begin
            bus(1'b0, `ULEF_LSR_OFF, lsr_tab[k]);
            bus(1'b0, `ULEF_RXDATA_OFF, {24'h0, d[k]});
        end
        bus(1'b0, `ULEF_LSR_OFF, 32'h0000_0000);
        $display("test fifo done");
        // sticky status, mask and clear on read
        bus(1'b0, `ULEF_STS_OFF, 32'h0000_001C);
        bus(1'b0, `ULEF_STS_OFF, 32'h0000_0000);
        bus(1'b1, `ULEF_IER_OFF, 32'h0000_0000);
        send(fr(8'($random(seed)), 1'b0, 1'b1), 9'd176);
        check_irq(1'b0);
        bus(1'b1, `ULEF_MSK_OFF, 32'h0000_0004);
        repeat (3) @(posedge clock);
        check_irq(1'b1);
        bus(1'b0, `ULEF_STS_OFF, 32'h0000_0004);
        repeat (3) @(posedge clock);
        check_irq(1'b0);
        $display("test events done");
        print_verdict();
    end
endmodule : uart_rx_line_error_flags_bench

// >>> test/ulef_line_model.sv
// serial transmitter model standing on the receive line
// assumes the bench pulses go for one cycle while busy is low
`timescale 1ns/1ns

module ulef_line_model (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        go,
    input  wire logic [11:0] frame,
    input  wire logic [8:0]  len,
    input  wire logic [7:0]  div,
    output logic             busy,
    output logic             serial_receive_input
);
    logic [8:0]  cnt_q;
    logic [11:0] frm_q;
    logic [3:0]  idx;

    // bit index from elapsed cycles; past bit 11 the line stays low
    assign idx = 4'(cnt_q / {1'b0, div});
    assign serial_receive_input = !busy ? 1'b1 :
                                  (idx < 4'd12) ? frm_q[idx] : 1'b0;

    // frame timer, lsb first, idle level high between frames
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy  <= 1'b0;
            cnt_q <= 9'h000;
            frm_q <= 12'hfff;
        end else if (go && !busy) begin
            busy  <= 1'b1;
            cnt_q <= 9'h000;
            frm_q <= frame;
        end else if (busy) begin
            cnt_q <= cnt_q + 9'h001;
            busy  <= (cnt_q != len - 9'h001);
        end
    end
endmodule : ulef_line_model
